// >>> pps_params.svh
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// source bus layout
`define PPS_BUS_W        18
`define PPS_CH_W         6
`define PPS_RED_LSB      12
`define PPS_GREEN_LSB    6
`define PPS_BLUE_LSB     0

// power request bit positions inside the synchroniser
`define PPS_REQ_W        2
`define PPS_REQ_PANEL    0
`define PPS_REQ_CONTRAST 1

// position counters
`define PPS_CNT_W        12
`define PPS_CNT_RST      12'h000
`define PPS_CNT_ONE      12'h001
`define PPS_CNT_MAX      12'hFFF

// frame counter
`define PPS_FRM_W        8
`define PPS_FRM_RST      8'h00
`define PPS_FRM_ONE      8'h01

`endif

// >>> pps_pkg.sv
`include "pps_params.svh"

package pps_pkg;

  typedef struct packed {
    logic [`PPS_CH_W-1:0] red;
    logic [`PPS_CH_W-1:0] green;
    logic [`PPS_CH_W-1:0] blue;
  } pps_pixel_t;

  typedef struct packed {
    logic active;
    logic line_sync;
    logic frame_sync;
  } pps_ctrl_t;

  typedef enum logic [0:0] {
    PPS_SEEK = 1'b0,
    PPS_RUN  = 1'b1
  } pps_phase_t;

  typedef struct packed {
    logic [`PPS_REQ_W-1:0] meta;
    logic [`PPS_REQ_W-1:0] stable;
  } pps_sync_t;

  typedef struct packed {
    pps_pixel_t            pix_in;
    pps_ctrl_t             ctl_in;
    pps_ctrl_t             ctl_prev;
    pps_phase_t            phase;
    logic                  ext_sel;
    pps_pixel_t            pix_out;
    logic                  valid;
    logic                  line_start;
    logic                  frame_start;
    logic [`PPS_CNT_W-1:0] pix_cnt;
    logic [`PPS_CNT_W-1:0] line_cnt;
    logic [`PPS_CNT_W-1:0] pix_idx;
    logic [`PPS_CNT_W-1:0] line_idx;
    logic [`PPS_FRM_W-1:0] frame_cnt;
    logic                  panel_en;
    logic                  contrast_en;
  } pps_state_t;

endpackage : pps_pkg

// >>> pps_req_sync.sv
`timescale 1ns/100ps
`include "pps_params.svh"

module pps_req_sync (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic [`PPS_REQ_W-1:0]  async_in,
  output logic      [`PPS_REQ_W-1:0]  sync_out
);
  import pps_pkg::*;

  pps_sync_t st;
  pps_sync_t next_st;

  // meta feeds only the second stage
  always_comb begin
    next_st        = st;
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule : pps_req_sync

// >>> pps_input_stage.sv
`timescale 1ns/100ps
`include "pps_params.svh"


module pps_input_stage (
  input  wire logic                   REF_CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CLK_EN,
  input  wire logic [`PPS_BUS_W-1:0]  SOURCE_PIXEL_BUS,
  input  wire logic                   ACTIVE_VIDEO_FLAG,
  input  wire logic                   LINE_BLANK_SYNC_IN,
  input  wire logic                   FRAME_BLANK_SYNC_IN,
  input  wire logic                   PANEL_POWER_REQUEST,
  input  wire logic                   CONTRAST_POWER_REQUEST,
  input  wire logic                   EXT_POWER_SEQ_SEL,
  input  wire logic                   INT_PANEL_SUPPLY_REQ,
  input  wire logic                   INT_CONTRAST_REQ,
  output pps_pkg::pps_pixel_t         PIXEL_OUT,
  output logic                        PIXEL_VALID,
  output logic                        LINE_START,
  output logic                        FRAME_START,
  output logic      [`PPS_CNT_W-1:0]  PIXEL_INDEX,
  output logic      [`PPS_CNT_W-1:0]  LINE_INDEX,
  output logic      [`PPS_FRM_W-1:0]  FRAME_COUNT,
  output logic                        IN_FRAME,
  output logic                        PANEL_SUPPLY_ENABLE_OUT,
  output logic                        CONTRAST_ENABLE_OUT
);
  import pps_pkg::*;

  pps_state_t            st;
  pps_state_t            next_st;
  logic [`PPS_REQ_W-1:0] req_raw;
  logic [`PPS_REQ_W-1:0] req_sync;

  // pixel data is valid only when enabled and neither blanking sync is up
  function automatic logic pixel_ok(input pps_ctrl_t c);
    pixel_ok = c.active & ~c.line_sync & ~c.frame_sync;
  endfunction : pixel_ok

  // split the 18-bit source word into its three 6-bit channels
  function automatic pps_pixel_t unpack_bus(input logic [`PPS_BUS_W-1:0] bus);
    unpack_bus.red   = bus[`PPS_RED_LSB   +: `PPS_CH_W];
    unpack_bus.green = bus[`PPS_GREEN_LSB +: `PPS_CH_W];
    unpack_bus.blue  = bus[`PPS_BLUE_LSB  +: `PPS_CH_W];
  endfunction : unpack_bus

  // power requests come from another chip's pins, so they get two flops
  assign req_raw[`PPS_REQ_PANEL]    = PANEL_POWER_REQUEST;
  assign req_raw[`PPS_REQ_CONTRAST] = CONTRAST_POWER_REQUEST;

  pps_req_sync u_req_sync (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .ce       (CLK_EN),
    .async_in (req_raw),
    .sync_out (req_sync)
  );

  always_comb begin
    logic line_fall;
    logic frame_fall;
    logic ok;
    line_fall  = 1'b0;
    frame_fall = 1'b0;
    ok         = 1'b0;
    next_st    = st;

    // pixel bus and its controls are launched on this same clock, so one
    // capture register is enough and no synchroniser is wanted here
    next_st.pix_in            = unpack_bus(SOURCE_PIXEL_BUS);
    next_st.ctl_in.active     = ACTIVE_VIDEO_FLAG;
    next_st.ctl_in.line_sync  = LINE_BLANK_SYNC_IN;
    next_st.ctl_in.frame_sync = FRAME_BLANK_SYNC_IN;
    next_st.ctl_prev          = st.ctl_in;

    // select is static, sampled once per clock with no filtering
    next_st.ext_sel = EXT_POWER_SEQ_SEL;

    // end of blanking opens a new line or frame
    line_fall  = st.ctl_prev.line_sync & ~st.ctl_in.line_sync;
    frame_fall = st.ctl_prev.frame_sync & ~st.ctl_in.frame_sync;
    ok         = pixel_ok(st.ctl_in);

    next_st.line_start  = 1'b0;
    next_st.frame_start = 1'b0;
    next_st.valid       = 1'b0;

    unique case (st.phase)
      PPS_SEEK: begin
        // no pixel is passed on until a frame boundary has been seen
        if (frame_fall) begin
          next_st.phase       = PPS_RUN;
          next_st.frame_start = 1'b1;
          next_st.line_start  = 1'b1;
          next_st.line_cnt    = `PPS_CNT_RST;
          next_st.pix_cnt     = `PPS_CNT_RST;
        end
      end
      PPS_RUN: begin
        if (frame_fall) begin
          next_st.frame_start = 1'b1;
          next_st.line_start  = 1'b1;
          next_st.line_cnt    = `PPS_CNT_RST;
          next_st.pix_cnt     = `PPS_CNT_RST;
          next_st.frame_cnt   = st.frame_cnt + `PPS_FRM_ONE;
        end else if (line_fall && !st.ctl_in.frame_sync) begin
          next_st.line_start = 1'b1;
          next_st.pix_cnt    = `PPS_CNT_RST;
          // saturate rather than wrap, so an oversize line count is visible
          if (st.line_cnt != `PPS_CNT_MAX) begin
            next_st.line_cnt = st.line_cnt + `PPS_CNT_ONE;
          end
        end
      end
    endcase

    // a pixel may arrive in the very cycle a line opens; it is pixel zero
    if (ok) begin
      if (next_st.phase == PPS_RUN) begin
        next_st.valid    = 1'b1;
        next_st.pix_out  = st.pix_in;
        next_st.pix_idx  = next_st.pix_cnt;
        next_st.line_idx = next_st.line_cnt;
        if (next_st.pix_cnt != `PPS_CNT_MAX) begin
          next_st.pix_cnt = next_st.pix_cnt + `PPS_CNT_ONE;
        end
      end
    end

    // power enables: pass-through in external mode, sequencer otherwise
    if (st.ext_sel) begin
      next_st.panel_en    = req_sync[`PPS_REQ_PANEL];
      next_st.contrast_en = req_sync[`PPS_REQ_CONTRAST];
    end else begin
      next_st.panel_en    = INT_PANEL_SUPPLY_REQ;
      next_st.contrast_en = INT_CONTRAST_REQ;
    end
  end

  // single clock for everything; relies on the pixel clock never stopping
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st <= '0;
    end else if (CLK_EN) begin
      st <= next_st;
    end
  end

  assign PIXEL_OUT               = st.pix_out;
  assign PIXEL_VALID             = st.valid;
  assign LINE_START              = st.line_start;
  assign FRAME_START             = st.frame_start;
  assign PIXEL_INDEX             = st.pix_idx;
  assign LINE_INDEX              = st.line_idx;
  assign FRAME_COUNT             = st.frame_cnt;
  assign IN_FRAME                = (st.phase == PPS_RUN);
  assign PANEL_SUPPLY_ENABLE_OUT = st.panel_en;
  assign CONTRAST_ENABLE_OUT     = st.contrast_en;

endmodule : pps_input_stage

// >>> pps_properties.sv
`timescale 1ns/100ps
module pps_properties (
  input wire logic                 REF_CLK,
  input wire logic                 SYS_RST,
  input wire logic [17:0]          SOURCE_PIXEL_BUS,
  input wire logic                 ACTIVE_VIDEO_FLAG,
  input wire logic                 LINE_BLANK_SYNC_IN,
  input wire logic                 FRAME_BLANK_SYNC_IN,
  input wire logic                 PANEL_POWER_REQUEST,
  input wire logic                 CONTRAST_POWER_REQUEST,
  input wire logic                 EXT_POWER_SEQ_SEL,
  input wire logic                 INT_PANEL_SUPPLY_REQ,
  input wire logic                 INT_CONTRAST_REQ,
  input wire pps_pkg::pps_pixel_t  PIXEL_OUT,
  input wire logic                 PIXEL_VALID,
  input wire logic                 LINE_START,
  input wire logic                 FRAME_START,
  input wire logic [11:0]          PIXEL_INDEX,
  input wire logic                 PANEL_SUPPLY_ENABLE_OUT,
  input wire logic                 CONTRAST_ENABLE_OUT
);
  import pps_pkg::*;
  wire logic ok_in = ACTIVE_VIDEO_FLAG & ~LINE_BLANK_SYNC_IN & ~FRAME_BLANK_SYNC_IN;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  chk_valid_cause: assert property (PIXEL_VALID |-> $past(ok_in, 2))
    else $error("valid beat without a clean capture");
  chk_pixel_map: assert property (PIXEL_VALID |-> PIXEL_OUT == $past(SOURCE_PIXEL_BUS, 2))
    else $error("pixel channels misplaced");
  chk_frame_fall: assert property (FRAME_START ==
    ($past(FRAME_BLANK_SYNC_IN, 3) && !$past(FRAME_BLANK_SYNC_IN, 2)))
    else $error("frame start not at end of frame blanking");
  chk_line_fall: assert property ($past(LINE_BLANK_SYNC_IN, 3) && !$past(LINE_BLANK_SYNC_IN, 2)
    && !$past(FRAME_BLANK_SYNC_IN, 2) && !$past(FRAME_BLANK_SYNC_IN, 3) |-> LINE_START)
    else $error("line start missing");
  chk_index_zero: assert property (LINE_START && PIXEL_VALID |-> PIXEL_INDEX == 12'h000)
    else $error("first pixel index not zero");
  chk_index_step: assert property (PIXEL_VALID && !LINE_START && $past(PIXEL_VALID)
    |-> PIXEL_INDEX == $past(PIXEL_INDEX) + 12'h001)
    else $error("pixel index did not step");
  // the select is captured once before use, so it is looked at two edges back
  chk_panel_ext: assert property ($past(EXT_POWER_SEQ_SEL, 2)
    |-> PANEL_SUPPLY_ENABLE_OUT == $past(PANEL_POWER_REQUEST, 3))
    else $error("panel enable not following request");
  chk_contrast_ext: assert property ($past(EXT_POWER_SEQ_SEL, 2)
    |-> CONTRAST_ENABLE_OUT == $past(CONTRAST_POWER_REQUEST, 3))
    else $error("contrast enable not following request");
  // sequencer requests go straight into the output flop
  chk_panel_int: assert property (!$past(SYS_RST) && !$past(EXT_POWER_SEQ_SEL, 2)
    |-> PANEL_SUPPLY_ENABLE_OUT == $past(INT_PANEL_SUPPLY_REQ))
    else $error("panel enable not from sequencer");
  chk_contrast_int: assert property (!$past(SYS_RST) && !$past(EXT_POWER_SEQ_SEL, 2)
    |-> CONTRAST_ENABLE_OUT == $past(INT_CONTRAST_REQ))
    else $error("contrast enable not from sequencer");
  cover property (FRAME_START ##1 PIXEL_VALID);
  cover property (LINE_START && !FRAME_START);
  cover property ($rose(PANEL_SUPPLY_ENABLE_OUT) && EXT_POWER_SEQ_SEL);
endmodule : pps_properties

bind pps_input_stage pps_properties pps_properties_inst (.*);

// >>> pps_video_source.sv
`timescale 1ns/100ps
module pps_video_source (
  input  wire logic          clk,
  output logic [17:0]        bus,
  output pps_pkg::pps_ctrl_t ctl
);
  import pps_pkg::*;
  initial begin
    bus = 18'h00000;
    ctl = '0;
  end
  // drive on the falling edge so the sampling edge sees settled lines
  task automatic beat(input logic a, input logic h, input logic v, input logic [17:0] d);
    @(negedge clk);
    ctl = '{a, h, v};
    bus = d;
  endtask : beat
  // blanking beats keep the flag up and scramble the bus: they must still be dropped
  task automatic send_frame();
    beat(1'b1, 1'b0, 1'b1, ~bus);
    beat(1'b1, 1'b0, 1'b1, ~bus);
    for (int l = 0; l < 2; l++) begin
      if (l > 0) begin
        beat(1'b1, 1'b1, 1'b0, ~bus);
        beat(1'b1, 1'b1, 1'b0, ~bus);
      end
      for (int p = 0; p < 4; p++)
        beat(1'b1, 1'b0, 1'b0, {6'(l + 1), 6'(p), 6'h3F - 6'(p)});
      beat(1'b0, 1'b0, 1'b0, ~bus);
    end
  endtask : send_frame
endmodule : pps_video_source

// >>> pps_input_stage_tb_top.sv
`timescale 1ns/100ps
module pps_input_stage_tb_top;
  import pps_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ext = 1'b0;
  logic [3:0]  req = 4'h0;
  logic [17:0] bus;
  pps_ctrl_t   ctl;
  pps_pixel_t  pix;
  logic        valid, ls, fs, inf, pout, cout;
  logic [11:0] pidx, lidx;
  logic [7:0]  fcnt;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  pps_video_source pps_video_source_inst (.clk(clk), .bus(bus), .ctl(ctl));
  pps_input_stage pps_input_stage_inst (
    .REF_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .SOURCE_PIXEL_BUS(bus),
    .ACTIVE_VIDEO_FLAG(ctl.active), .LINE_BLANK_SYNC_IN(ctl.line_sync),
    .FRAME_BLANK_SYNC_IN(ctl.frame_sync), .PANEL_POWER_REQUEST(req[3]),
    .CONTRAST_POWER_REQUEST(req[2]), .EXT_POWER_SEQ_SEL(ext), .INT_PANEL_SUPPLY_REQ(req[1]),
    .INT_CONTRAST_REQ(req[0]), .PIXEL_OUT(pix), .PIXEL_VALID(valid), .LINE_START(ls),
    .FRAME_START(fs), .PIXEL_INDEX(pidx), .LINE_INDEX(lidx), .FRAME_COUNT(fcnt),
    .IN_FRAME(inf), .PANEL_SUPPLY_ENABLE_OUT(pout), .CONTRAST_ENABLE_OUT(cout));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // hang guard: the whole run needs about 70 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fails++;
      results();
    end
  end
  task automatic test_stream(input logic [7:0] frames_after);
    logic [11:0] n;
    logic [3:0]  nf;
    logic [3:0]  nl;
    n = 12'h000;
    nf = 4'h0;
    nl = 4'h0;
    fork
      pps_video_source_inst.send_frame();
      repeat (24) begin
        @(negedge clk);
        nf = nf + 4'(fs === 1'b1);
        nl = nl + 4'(ls === 1'b1);
        if (valid === 1'b1) begin
          check(pix, {6'(n[11:2] + 12'h001), 6'(n[1:0]), 6'h3F - 6'(n[1:0])});
          check(18'(pidx), 18'(n[1:0]));
          check(18'(lidx), 18'(n[11:2]));
          n++;
        end
      end
    join
    check(18'(n), 18'h00008);
    check(18'(nl), 18'h00002);
    check(18'({nf, fcnt, inf}), 18'({4'h1, frames_after, 1'b1}));
  endtask : test_stream
  task automatic power(input logic e, input logic [3:0] r, input logic [1:0] exp);
    @(negedge clk);
    ext = e;
    req = r;
    repeat (4) @(negedge clk);
    check(18'({pout, cout}), 18'(exp));
  endtask : power
  // pins and sequencer requests disagree on panel in every internal case and on contrast in the last, so an ignored pin shows
  task automatic test_power();
    power(1'b1, 4'b1000, 2'b10);
    power(1'b1, 4'b0111, 2'b01);
    power(1'b0, 4'b1101, 2'b01);
    power(1'b0, 4'b0110, 2'b10);
  endtask : test_power
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check(18'({valid, fs, ls, inf, pout, cout}), 18'h00000);
    test_stream(8'h00);
    test_stream(8'h01);
    test_power();
    results();
  end
endmodule : pps_input_stage_tb_top
